// >>> src/pidm_top.sv
/*
 * Polled I/O data mapper: decodes seven of the eight consumed bytes of the network
 * output instance into drive commands and setpoints, and builds the four
 * produced bytes of input instance 70 or 71 from drive feedback.
 * Assumes a classic Wishbone master on the register side that writes the
 * consumed bytes and reads the produced ones, and drive logic on the other
 * side that is synchronous to CLOCK.
 */
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "pidm_consts.svh"

module pidm_top
  import pidm_pkg::*;
(
  input  wire logic                     CLOCK,
  input  wire logic                     RESETN,
  input  wire logic                     WB_CYC_I,
  input  wire logic                     WB_STB_I,
  input  wire logic                     WB_WE_I,
  input  wire logic [7:0]               WB_ADR_I,
  input  wire logic [3:0]               WB_SEL_I,
  input  wire logic [31:0]              WB_DAT_I,
  output      logic [31:0]              WB_DAT_O,
  output      logic                     WB_ACK_O,
  input  wire logic                     LOCAL_FWD,
  input  wire logic                     LOCAL_REV,
  input  wire pidm_pkg::pidm_setpoint_t STORED_SET,
  input  wire pidm_pkg::pidm_feedback_t FEEDBACK,
  output      pidm_pkg::pidm_command_t  COMMAND,
  output      pidm_pkg::pidm_setpoint_t SETPOINT,
  output      logic [31:0]              PRODUCED,
  output      logic                     PAIR_ERROR
);

  import pidm_pkg::*;

  pidm_top_state_t state;
  pidm_top_state_t next_state;

  logic [7:0] ctl;
  logic [7:0] ctl_rise;
  logic [7:0] out_inst;
  logic [7:0] in_inst;
  logic [7:0] word_adr;
  logic       bus_req;

  assign ctl      = state.out_w0[7:0];
  assign out_inst = state.cfg[7:0];
  assign in_inst  = state.cfg[15:8];
  assign word_adr = {WB_ADR_I[7:2], 2'b00};
  assign bus_req  = WB_CYC_I & WB_STB_I;

  // Edges of the control byte drive the fault reset pulse and run arming.
  pidm_rise #(
    .WIDTH (8)
  ) u_ctl_rise (
    .clock  (CLOCK),
    .resetn (RESETN),
    .level  (ctl),
    .rise   (ctl_rise)
  );

  // Applies the enabled byte lanes of a write onto a stored word.
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0]  sel);
    logic [31:0] result;
    result = old_word;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        result[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return result;
  endfunction

  // Builds the produced status byte for the selected input instance.
  function automatic logic [7:0] status_byte(input logic [7:0]     inst,
                                             input pidm_feedback_t fb,
                                             input logic [7:0]     c);
    logic [7:0] result;
    result = 8'h00;
    if (inst == `PIDM_INST_IN_70) begin
      result[`PIDM_ST_TRIP] = fb.trip;
      result[`PIDM_ST_FWD]  = fb.running_fwd;
    end else begin
      result[`PIDM_ST_TRIP]    = fb.trip;
      result[`PIDM_ST_WARN]    = fb.warning;
      result[`PIDM_ST_FWD]     = fb.running_fwd;
      result[`PIDM_ST_REV]     = fb.running_rev;
      result[`PIDM_ST_READY]   = fb.ready;
      result[`PIDM_ST_NET_RUN] = c[`PIDM_CTL_NET_RUN];
      result[`PIDM_ST_NET_REF] = c[`PIDM_CTL_NET_REF];
      result[`PIDM_ST_ARRIVAL] = fb.arrival;
    end
    return result;
  endfunction

  always_comb begin
    logic        net_run;
    logic        net_ref;
    logic        want_fwd;
    logic        want_rev;
    logic [31:0] read_word;
    logic [31:0] cfg_word;
    net_run   = 1'b0;
    cfg_word  = 32'h0000_0000;
    net_ref   = 1'b0;
    want_fwd  = 1'b0;
    want_rev  = 1'b0;
    read_word = 32'h0000_0000;

    next_state = state;

    // Wishbone slave: one answer per request, ack dropped the cycle after.
    case (state.bus_state)
      PIDM_BUS_IDLE: begin
        next_state.ack = 1'b0;
        if (bus_req) begin
          case (word_adr)
            `PIDM_ADR_OUT_W0: begin
              read_word = state.out_w0;
            end
            `PIDM_ADR_OUT_W1: begin
              read_word = state.out_w1;
            end
            `PIDM_ADR_CFG: begin
              read_word = {16'h0000, state.cfg};
            end
            `PIDM_ADR_IN_DATA: begin
              read_word = state.produced;
            end
            `PIDM_ADR_STATUS: begin
              read_word = 32'h0000_0000;
              read_word[`PIDM_STAT_PAIR_ERR]  = state.pair_err;
              read_word[`PIDM_STAT_FWD_ARMED] = state.fwd_armed;
              read_word[`PIDM_STAT_REV_ARMED] = state.rev_armed;
            end
            default: begin
              read_word = 32'h0000_0000;
            end
          endcase
          if (WB_WE_I) begin
            case (word_adr)
              `PIDM_ADR_OUT_W0: begin
                next_state.out_w0 = merge_lanes(state.out_w0, WB_DAT_I, WB_SEL_I);
              end
              `PIDM_ADR_OUT_W1: begin
                next_state.out_w1 = merge_lanes(state.out_w1, WB_DAT_I, WB_SEL_I);
              end
              `PIDM_ADR_CFG: begin
                cfg_word       = merge_lanes({16'h0000, state.cfg}, WB_DAT_I, WB_SEL_I);
                next_state.cfg = cfg_word[15:0];
              end
              default: begin
                next_state.cfg = state.cfg;
              end
            endcase
            next_state.dat_o = 32'h0000_0000;
          end else begin
            next_state.dat_o = read_word;
          end
          next_state.ack       = 1'b1;
          next_state.bus_state = PIDM_BUS_ACK;
        end
      end
      PIDM_BUS_ACK: begin
        next_state.ack       = 1'b0;
        next_state.dat_o     = 32'h0000_0000;
        next_state.bus_state = PIDM_BUS_IDLE;
      end
      default: begin
        next_state.ack       = 1'b0;
        next_state.bus_state = PIDM_BUS_IDLE;
      end
    endcase

    // Only the named control bits are decoded; bits 4 and 7 and byte 1
    // have no effect on the drive.
    net_run = ctl[`PIDM_CTL_NET_RUN];
    net_ref = ctl[`PIDM_CTL_NET_REF];

    // A run bit arms only on its own rise while network control already
    // stands; a rise in the same write as network control does not count.
    if (!ctl[`PIDM_CTL_FWD] || !net_run) begin
      next_state.fwd_armed = 1'b0;
    end else if (ctl_rise[`PIDM_CTL_FWD] && !ctl_rise[`PIDM_CTL_NET_RUN]) begin
      next_state.fwd_armed = 1'b1;
    end
    if (!ctl[`PIDM_CTL_REV] || !net_run) begin
      next_state.rev_armed = 1'b0;
    end else if (ctl_rise[`PIDM_CTL_REV] && !ctl_rise[`PIDM_CTL_NET_RUN]) begin
      next_state.rev_armed = 1'b1;
    end

    if (net_run) begin
      want_fwd = state.fwd_armed;
      want_rev = state.rev_armed;
    end else begin
      want_fwd = LOCAL_FWD;
      want_rev = LOCAL_REV;
    end

    // Both directions at once, or a coast request, leave the drive unpowered.
    next_state.command.coast       = ctl[`PIDM_CTL_COAST];
    next_state.command.run_fwd     = want_fwd & ~want_rev & ~ctl[`PIDM_CTL_COAST];
    next_state.command.run_rev     = want_rev & ~want_fwd & ~ctl[`PIDM_CTL_COAST];
    next_state.command.fault_reset = ctl_rise[`PIDM_CTL_FAULT_RST];

    if (net_ref) begin
      next_state.setpoint.freq  = state.out_w0[31:16];
      next_state.setpoint.accel = state.out_w1[15:0];
      next_state.setpoint.decel = state.out_w1[31:16];
    end else begin
      next_state.setpoint = STORED_SET;
    end

    next_state.produced[7:0]   = status_byte(in_inst, FEEDBACK, ctl);
    next_state.produced[15:8]  = {5'h00, FEEDBACK.state_code};
    next_state.produced[31:16] = FEEDBACK.freq_mon;

    next_state.pair_err = !(((out_inst == `PIDM_INST_OUT_20)  && (in_inst == `PIDM_INST_IN_70))
                         || ((out_inst == `PIDM_INST_OUT_21)  && (in_inst == `PIDM_INST_IN_71))
                         || ((out_inst == `PIDM_INST_OUT_100) && (in_inst == `PIDM_INST_IN_101)));
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state           <= '0;
      state.bus_state <= PIDM_BUS_IDLE;
      state.out_w0    <= `PIDM_RST_OUT_W0;
      state.out_w1    <= `PIDM_RST_OUT_W1;
      state.cfg       <= `PIDM_RST_CFG;
    end else begin
      state <= next_state;
    end
  end

  assign WB_DAT_O   = state.dat_o;
  assign WB_ACK_O   = state.ack;
  assign COMMAND    = state.command;
  assign SETPOINT   = state.setpoint;
  assign PRODUCED   = state.produced;
  assign PAIR_ERROR = state.pair_err;

endmodule

`default_nettype wire

// >>> src/pidm_consts.svh
/*
 * Constants of the polled I/O data mapper: register offsets, reset values,
 * control and status bit positions, and instance numbers.
 * Assumes it is included by its bare name from src/ and defines nothing else.
 */
`ifndef PIDM_CONSTS_SVH
`define PIDM_CONSTS_SVH

// Register byte offsets on the Wishbone slave.
`define PIDM_ADR_OUT_W0     8'h00
`define PIDM_ADR_OUT_W1     8'h04
`define PIDM_ADR_CFG        8'h08
`define PIDM_ADR_IN_DATA    8'h0c
`define PIDM_ADR_STATUS     8'h10

// Reset values.
`define PIDM_RST_OUT_W0     32'h0000_0000
`define PIDM_RST_OUT_W1     32'h0000_0000
`define PIDM_RST_CFG        16'h6564

// Consumed control byte bit positions.
`define PIDM_CTL_FWD        0
`define PIDM_CTL_REV        1
`define PIDM_CTL_FAULT_RST  2
`define PIDM_CTL_COAST      3
`define PIDM_CTL_NET_RUN    5
`define PIDM_CTL_NET_REF    6

// Produced status byte bit positions.
`define PIDM_ST_TRIP        0
`define PIDM_ST_WARN        1
`define PIDM_ST_FWD         2
`define PIDM_ST_REV         3
`define PIDM_ST_READY       4
`define PIDM_ST_NET_RUN     5
`define PIDM_ST_NET_REF     6
`define PIDM_ST_ARRIVAL     7

// Instance numbers.
`define PIDM_INST_OUT_20    8'h14
`define PIDM_INST_OUT_21    8'h15
`define PIDM_INST_OUT_100   8'h64
`define PIDM_INST_IN_70     8'h46
`define PIDM_INST_IN_71     8'h47
`define PIDM_INST_IN_101    8'h65

// Status register bit positions.
`define PIDM_STAT_PAIR_ERR  0
`define PIDM_STAT_FWD_ARMED 1
`define PIDM_STAT_REV_ARMED 2

`endif

// >>> src/pidm_pkg.sv
/*
 * Types of the polled I/O data mapper: drive-side carriers and the state
 * record of the top module.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pidm_pkg;

  typedef enum logic [0:0] {
    PIDM_BUS_IDLE = 1'b0,
    PIDM_BUS_ACK  = 1'b1
  } pidm_bus_state_t;

  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] accel;
    logic [15:0] decel;
  } pidm_setpoint_t;

  typedef struct packed {
    logic        trip;
    logic        warning;
    logic        ready;
    logic        arrival;
    logic        running_fwd;
    logic        running_rev;
    logic [2:0]  state_code;
    logic [15:0] freq_mon;
  } pidm_feedback_t;

  typedef struct packed {
    logic run_fwd;
    logic run_rev;
    logic coast;
    logic fault_reset;
  } pidm_command_t;

  typedef struct packed {
    pidm_bus_state_t bus_state;
    logic            ack;
    logic [31:0]     dat_o;
    logic [31:0]     out_w0;
    logic [31:0]     out_w1;
    logic [15:0]     cfg;
    logic            fwd_armed;
    logic            rev_armed;
    logic            pair_err;
    logic [31:0]     produced;
    pidm_command_t   command;
    pidm_setpoint_t  setpoint;
  } pidm_top_state_t;

endpackage

// >>> src/pidm_rise.sv
/*
 * Rising-edge detector over a vector of levels; one pulse per bit that goes
 * from zero to one between two clock edges.
 * Assumes the levels are synchronous to CLOCK.
 */
`timescale 1ns/1ps
`default_nettype none

module pidm_rise #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] level,
  output      logic [WIDTH-1:0] rise
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
  } pidm_rise_state_t;

  pidm_rise_state_t state;
  pidm_rise_state_t next_state;

  always_comb begin
    next_state.prev = level;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rise = level & ~state.prev;

endmodule

`default_nettype wire

// >>> bench/pidm_drive_model.sv
/*
 * Drive-side partner: latches a trip, reports run state and a monitor value.
 * Assumes COMMAND from the mapper and stimulus from the bench on one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pidm_drive_model
  import pidm_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    resetn,
  input  wire pidm_pkg::pidm_command_t command,
  input  wire logic                    trip_set,
  input  wire logic [16:0]             mon,
  output      pidm_pkg::pidm_feedback_t feedback
);
  logic       trip;
  logic [2:0] code;
  always_ff @(posedge clock) begin
    if (!resetn || command.fault_reset) trip <= 1'b0;
    else if (trip_set) trip <= 1'b1;
  end
  // The state code follows the command: coasting, running or stopped.
  assign code = command.coast ? 3'h3 : (command.run_fwd | command.run_rev) ? 3'h1 : 3'h0;
  assign feedback = '{trip, trip_set, !trip, mon[16], command.run_fwd, command.run_rev,
                      code, mon[15:0]};
endmodule
`default_nettype wire

// >>> bench/pidm_monitor.sv
/*
 * Concurrent checks on the mapper's ports, bound into every pidm_top.
 * Assumes one clock domain and the synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module pidm_monitor
  import pidm_pkg::*;
(
  input  wire logic                     CLOCK,
  input  wire logic                     RESETN,
  input  wire logic                     WB_CYC_I,
  input  wire logic                     WB_STB_I,
  input  wire logic [31:0]              WB_DAT_O,
  input  wire logic                     WB_ACK_O,
  input  wire pidm_pkg::pidm_feedback_t FEEDBACK,
  input  wire pidm_pkg::pidm_command_t  COMMAND,
  input  wire logic [31:0]              PRODUCED
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  ack_after_req_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not acked in one cycle");
  dat_idle_zero_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("read data outside ack");
  freq_mon_a: assert property ($past(RESETN, 2) |-> PRODUCED[31:16] == $past(FEEDBACK.freq_mon))
    else $error("frequency monitor bytes wrong");
  state_code_a: assert property ($past(RESETN, 2) |-> PRODUCED[15:8] == {5'h0, $past(FEEDBACK.state_code)})
    else $error("state code byte wrong");
  reset_pulse_a: assert property (COMMAND.fault_reset |=> !COMMAND.fault_reset) else $error("reset pulse too long");
  coast_stops_a: assert property (COMMAND.coast |-> !COMMAND.run_fwd && !COMMAND.run_rev) else $error("run while coasting");
  one_dir_a: assert property (!(COMMAND.run_fwd && COMMAND.run_rev)) else $error("both directions on");
  cover property (WB_ACK_O && WB_CYC_I);
  cover property (COMMAND.run_fwd);
  cover property (COMMAND.fault_reset);
  cover property (COMMAND.coast);
endmodule
bind pidm_top pidm_monitor u_mon (.CLOCK(CLOCK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .FEEDBACK(FEEDBACK), .COMMAND(COMMAND), .PRODUCED(PRODUCED));
`default_nettype wire

// >>> bench/tb_top.sv
/*
 * Self-checking bench of the mapper: Wishbone master tasks, drive partner.
 * Assumes the register map and latencies of the designer's hand-over.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pidm_pkg::*;
  logic           clock, resetn, cyc, stb, we, ack, pair_err, lfwd, lrev, trip_set;
  logic [7:0]     adr;
  logic [3:0]     sel;
  logic [31:0]    dat_i, dat_o, produced, q, w1;
  logic [16:0]    mon;
  logic [15:0]    f;
  logic [7:0]     inst;
  pidm_setpoint_t stored, setpoint;
  pidm_feedback_t fb;
  pidm_command_t  command;
  int             fail_count, total_checks;
  pidm_top dut (.CLOCK(clock), .RESETN(resetn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .LOCAL_FWD(lfwd), .LOCAL_REV(lrev), .STORED_SET(stored), .FEEDBACK(fb), .COMMAND(command),
    .SETPOINT(setpoint), .PRODUCED(produced), .PAIR_ERROR(pair_err));
  pidm_drive_model drv (.clock(clock), .resetn(resetn), .command(command), .trip_set(trip_set),
    .mon(mon), .feedback(fb));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    {cyc, stb, we, adr, sel, dat_i} <= {2'b11, w, a, 4'hf, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    {cyc, stb} <= 2'b00;
    if (n >= 20) begin
      fail_count++;
      end_of_test();
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask
  // Expected produced word from the drive feedback, instance and control byte.
  function automatic logic [31:0] exp_prod(input logic [7:0] in_inst, input logic [7:0] ctl);
    logic [7:0] st;
    st = (in_inst == 8'h46) ? {5'h0, fb.running_fwd, 1'b0, fb.trip} :
      {fb.arrival, ctl[6], ctl[5], fb.ready, fb.running_rev, fb.running_fwd, fb.warning, fb.trip};
    return {fb.freq_mon, 5'h0, fb.state_code, st};
  endfunction
  initial begin
    #(3000 * 100);
    fail_count++;
    end_of_test();
  end
  initial begin
    {cyc, stb, we, adr, sel, dat_i, lfwd, lrev, trip_set, resetn} = '0;
    stored = '0;
    mon = '0;
    fail_count = 0;
    total_checks = 0;
    void'($urandom(32'h130fb68a));
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    stored <= 48'({$urandom, $urandom});
    mon <= 17'($urandom);
    wb(0, 8'h08, 0); chk(q, 32'h6564);
    wb(0, 8'h00, 0); chk(q, 0);
    wb(0, 8'h20, 0); chk(q, 0);
    f = 16'($urandom);
    w1 = $urandom;
    wb(1, 8'h04, w1);
    wb(1, 8'h00, {f, 16'h0040});
    settle(); chk(setpoint, {f, w1[15:0], w1[31:16]});
    wb(1, 8'h00, 32'h0000_ff80);
    settle(); chk(setpoint, stored);
    wb(1, 8'h00, 32'h61);
    settle(); chk(command, 4'h0);
    wb(1, 8'h00, 32'h60);
    wb(1, 8'h00, 32'h61);
    settle(); chk(command, 4'h8);
    for (int i = 0; i < 2; i++) begin
      inst = 8'h46 + 8'(i);
      wb(1, 8'h08, {16'h0, inst, 8'h64});
      settle(); chk(produced, exp_prod(inst, 8'h61));
      wb(0, 8'h0c, 0); chk(q, exp_prod(inst, 8'h61));
      chk(pair_err, 1'b1);
    end
    wb(1, 8'h00, 32'h62);
    settle(); chk(command, 4'h4);
    wb(1, 8'h00, 32'h6a);
    settle(); chk(command, 4'h2);
    @(posedge clock) trip_set <= 1'b1;
    @(posedge clock) trip_set <= 1'b0;
    settle(); chk(produced, exp_prod(8'h47, 8'h6a));
    wb(1, 8'h00, 32'h64);
    settle(); chk(fb.trip, 1'b0);
    chk(produced, exp_prod(8'h47, 8'h64));
    wb(1, 8'h00, 32'h0);
    lfwd <= 1'b1;
    settle(); chk(command, 4'h8);
    wb(1, 8'h08, 32'h4614);
    settle(); chk(pair_err, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
